/* shared/iop_consts.vh */
// constants for the i/o port, external interrupt and clock control block
//
// Behaviour
// - For pins with pull-up, direction/option 00 float in, 01 pull-up interrupt in, 10 open-drain out, 11 push-pull out.
// - The two true open-drain pins have no pull-up: 00 float in, 01 float interrupt in, direction 1 sinks only.
// - Bits 7:6 set group one sensitivity: 00 falling and low level, 01 rising, 10 falling, 11 both edges.
// - Bits 4:3 set group zero sensitivity with the same encoding.
// - The sensitivity fields take a write only while the condition code interrupt mask bit is 1.
// - Bit 5 set drives the cpu clock out on port c pin 2; clear leaves the pin to general i/o.
// - In slow mode bits 2:1 divide the oscillator: 00 by 4, 10 by 8, 01 by 16, 11 by 32.
// - Bit 0 clear gives the oscillator divided by 2; set selects slow mode and the prescaler.
// - The miscellaneous control register resets to all zeros.
`ifndef IOP_CONSTS_VH
`define IOP_CONSTS_VH

// register byte offsets
`define IOP_OFS_MISC     8'h00
`define IOP_OFS_DATA     8'h04
`define IOP_OFS_DIR      8'h08
`define IOP_OFS_OPT      8'h0c
`define IOP_OFS_LEVEL    8'h10
`define IOP_OFS_STATUS   8'h14
`define IOP_OFS_MASK     8'h18
`define IOP_OFS_ROUTE    8'h1c

// misc_control fields
`define IOP_MISC_RESET   8'h00
`define IOP_G1_SENS_HI   7
`define IOP_G1_SENS_LO   6
`define IOP_CLKOUT_BIT   5
`define IOP_G0_SENS_HI   4
`define IOP_G0_SENS_LO   3
`define IOP_PRESC_HI     2
`define IOP_PRESC_LO     1
`define IOP_SLOW_BIT     0

// sensitivity encodings
`define IOP_SENS_FALL_LOW 2'h0
`define IOP_SENS_RISE     2'h1
`define IOP_SENS_FALL     2'h2
`define IOP_SENS_BOTH     2'h3

// half periods of the cpu clock in oscillator cycles
`define IOP_HALF_NORM    5'h01
`define IOP_HALF_DIV4    5'h02
`define IOP_HALF_DIV8    5'h04
`define IOP_HALF_DIV16   5'h08
`define IOP_HALF_DIV32   5'h10

// pin layout: port a bits 7:0, port b 15:8, port c 23:16
`define IOP_NPINS        24
`define IOP_PORT_A_MASK  24'h0000ff
`define IOP_PORT_B_MASK  24'h00ff00
`define IOP_PORT_C_MASK  24'hff0000
`define IOP_TRUE_OD_MASK 24'h000050
`define IOP_CLKOUT_PIN   18

`endif

/* rtl/iop_sync.v */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module iop_sync #(
  parameter W = 24
) (
  // clock and reset
  input  wire         hclk,
  input  wire         hresetn,
  input  wire         ce,
  // raw and filtered levels
  input  wire [W-1:0] d_in,
  output reg  [W-1:0] q_out
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // s1 only feeds s2; a bit changes once stages two and three agree,
  // which rejects a sample caught while the first stage resolves
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_r  <= {W{1'b0}};
      s2_r  <= {W{1'b0}};
      s3_r  <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end
    else if (ce)
    begin
      s1_r  <= d_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      q_out <= (s2_r & ~(s2_r ^ s3_r)) | (q_out & (s2_r ^ s3_r));
    end
  end

endmodule

`default_nettype wire

/* rtl/iop_top.v */
// i/o ports a-c, external interrupt groups and cpu clock control behind ahb-lite
`timescale 1ns/1ps
`default_nettype none
`include "iop_consts.vh"

module iop_top (
  // clock, reset, enable
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // cpu status
  input  wire        cc_int_mask,
  // port pins
  input  wire [23:0] pin_in,
  output wire [23:0] pin_out,
  output wire [23:0] pin_oe,
  output wire [23:0] pin_pull_en,
  // clock and interrupt outputs
  output reg         cpu_clk,
  output wire        ext_int_group0,
  output wire        ext_int_group1,
  output wire        irq
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg  [7:0]  misc_control_r;
  reg  [23:0] data_r;
  reg  [23:0] dir_r;
  reg  [23:0] opt_r;
  reg  [1:0]  status_r;
  reg  [1:0]  mask_r;
  reg         route_r;
  reg  [23:0] prev_r;
  reg  [4:0]  div_cnt_r;
  reg  [7:0]  addr_r;
  reg         wr_pend_r;
  reg         rd_pend_r;
  reg         rd_wait_r;
  wire [23:0] level;

  wire [1:0] group1_sensitivity = misc_control_r[`IOP_G1_SENS_HI:`IOP_G1_SENS_LO];
  wire [1:0] group0_sensitivity = misc_control_r[`IOP_G0_SENS_HI:`IOP_G0_SENS_LO];
  wire       clock_out_enable   = misc_control_r[`IOP_CLKOUT_BIT];
  wire [1:0] slow_prescaler     = misc_control_r[`IOP_PRESC_HI:`IOP_PRESC_LO];
  wire       slow_mode_select   = misc_control_r[`IOP_SLOW_BIT];

  ////////////////////////////////////////////////////////////////////////
  // pin input synchroniser

  iop_sync #(
    .W       (`IOP_NPINS)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d_in    (pin_in),
    .q_out   (level)
  );

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave

  // reads take one wait state so hrdata always comes from a flop and
  // sees a write made in the cycle just before
  wire addr_phase = hsel & hready & htrans[1];
  wire wr_go      = wr_pend_r;
  wire wr_misc    = wr_go & (addr_r == `IOP_OFS_MISC);

  assign hreadyout = ~(rd_pend_r & ~rd_wait_r);
  assign hresp     = 1'b0;

  // address phase capture and data phase tracking
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_r    <= 8'h00;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
    end
    else if (ce)
    begin
      if (addr_phase)
      begin
        addr_r    <= {haddr[7:2], 2'h0};
        wr_pend_r <= hwrite;
        rd_pend_r <= ~hwrite;
        rd_wait_r <= 1'b0;
      end
      else if (hreadyout)
      begin
        wr_pend_r <= 1'b0;
        rd_pend_r <= 1'b0;
        rd_wait_r <= 1'b0;
      end
      else
      begin
        rd_wait_r <= 1'b1;
      end
    end
  end

  // read mux, loaded during the wait state; unmapped reads give zero
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
    end
    else if (ce && rd_pend_r && !rd_wait_r)
    begin
      case (addr_r)
        `IOP_OFS_MISC:   hrdata <= {24'h000000, misc_control_r};
        `IOP_OFS_DATA:   hrdata <= {8'h00, data_r};
        `IOP_OFS_DIR:    hrdata <= {8'h00, dir_r};
        `IOP_OFS_OPT:    hrdata <= {8'h00, opt_r};
        `IOP_OFS_LEVEL:  hrdata <= {8'h00, level};
        `IOP_OFS_STATUS: hrdata <= {30'h0, status_r};
        `IOP_OFS_MASK:   hrdata <= {30'h0, mask_r};
        `IOP_OFS_ROUTE:  hrdata <= {31'h0, route_r};
        default:         hrdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers

  // sensitivity fields only move while the cpu has interrupts masked
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      misc_control_r <= `IOP_MISC_RESET;
    end
    else if (ce && wr_misc)
    begin
      misc_control_r[`IOP_CLKOUT_BIT] <= hwdata[`IOP_CLKOUT_BIT];
      misc_control_r[`IOP_PRESC_HI:`IOP_PRESC_LO] <= hwdata[`IOP_PRESC_HI:`IOP_PRESC_LO];
      misc_control_r[`IOP_SLOW_BIT] <= hwdata[`IOP_SLOW_BIT];
      if (cc_int_mask)
      begin
        misc_control_r[`IOP_G1_SENS_HI:`IOP_G1_SENS_LO] <= hwdata[`IOP_G1_SENS_HI:`IOP_G1_SENS_LO];
        misc_control_r[`IOP_G0_SENS_HI:`IOP_G0_SENS_LO] <= hwdata[`IOP_G0_SENS_HI:`IOP_G0_SENS_LO];
      end
    end
  end

  // port data, direction, option, mask and port c routing
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_r  <= 24'h000000;
      dir_r   <= 24'h000000;
      opt_r   <= 24'h000000;
      mask_r  <= 2'h0;
      route_r <= 1'b0;
    end
    else if (ce && wr_go)
    begin
      case (addr_r)
        `IOP_OFS_DATA:  data_r  <= hwdata[23:0];
        `IOP_OFS_DIR:   dir_r   <= hwdata[23:0];
        `IOP_OFS_OPT:   opt_r   <= hwdata[23:0];
        `IOP_OFS_MASK:  mask_r  <= hwdata[1:0];
        `IOP_OFS_ROUTE: route_r <= hwdata[0];
        default:        route_r <= route_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers

  // one slice per pin; open-drain only ever drives low, true open-drain
  // pins never enable the pull-up and ignore the option bit as outputs
  genvar gi;
  generate
    for (gi = 0; gi < `IOP_NPINS; gi = gi + 1)
    begin : g_pin
      localparam TRUE_OD = ((`IOP_TRUE_OD_MASK >> gi) & 1) == 1;
      wire push_pull = dir_r[gi] & opt_r[gi] & !TRUE_OD;
      wire clk_pin   = (gi == `IOP_CLKOUT_PIN) && clock_out_enable;
      assign pin_out[gi]     = clk_pin ? cpu_clk : (push_pull & data_r[gi]);
      assign pin_oe[gi]      = clk_pin | (dir_r[gi] & (push_pull | ~data_r[gi]));
      assign pin_pull_en[gi] = ~dir_r[gi] & opt_r[gi] & !TRUE_OD;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // external interrupt detection

  // per-pin event for a sensitivity setting
  function [23:0] iop_event;
    input [1:0]  sens;
    input [23:0] rise;
    input [23:0] fall;
    input [23:0] low;
    begin
      case (sens)
        `IOP_SENS_FALL_LOW: iop_event = fall | low;
        `IOP_SENS_RISE:     iop_event = rise;
        `IOP_SENS_FALL:     iop_event = fall;
        default:            iop_event = rise | fall;
      endcase
    end
  endfunction

  wire [23:0] int_mode = ~dir_r & opt_r;
  wire [23:0] rise     = level & ~prev_r;
  wire [23:0] fall     = ~level & prev_r;
  wire [23:0] c_pins   = `IOP_PORT_C_MASK;
  wire [23:0] members0 = `IOP_PORT_A_MASK | (route_r ? 24'h000000 : c_pins);
  wire [23:0] members1 = `IOP_PORT_B_MASK | (route_r ? c_pins : 24'h000000);
  wire        ev0      = |(members0 & int_mode & iop_event(group0_sensitivity, rise, fall, ~level));
  wire        ev1      = |(members1 & int_mode & iop_event(group1_sensitivity, rise, fall, ~level));
  wire [1:0]  clr      = (wr_go && addr_r == `IOP_OFS_STATUS) ? hwdata[1:0] : 2'h0;

  // previous level for edges; a held low level sets the flag again
  // every cycle, so clearing it while the pin stays low does not stick
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_r   <= 24'h000000;
      status_r <= 2'h0;
    end
    else if (ce)
    begin
      prev_r   <= level;
      status_r <= (status_r & ~clr) | {ev1, ev0};
    end
  end

  assign ext_int_group0 = status_r[0];
  assign ext_int_group1 = status_r[1];
  assign irq            = |(status_r & mask_r);

  ////////////////////////////////////////////////////////////////////////
  // cpu clock divider

  reg [4:0] half_sel;

  // half period in oscillator cycles for the current mode
  always @*
  begin
    half_sel = `IOP_HALF_NORM;
    if (slow_mode_select)
    begin
      case (slow_prescaler)
        2'h0:    half_sel = `IOP_HALF_DIV4;
        2'h2:    half_sel = `IOP_HALF_DIV8;
        2'h1:    half_sel = `IOP_HALF_DIV16;
        default: half_sel = `IOP_HALF_DIV32;
      endcase
    end
  end

  // toggling at >= keeps a switch to a faster rate from overrunning
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_cnt_r <= 5'h00;
      cpu_clk   <= 1'b0;
    end
    else if (ce)
    begin
      if (div_cnt_r >= half_sel - 5'h01)
      begin
        div_cnt_r <= 5'h00;
        cpu_clk   <= ~cpu_clk;
      end
      else
      begin
        div_cnt_r <= div_cnt_r + 5'h01;
      end
    end
  end

endmodule

`default_nettype wire

/* verif/iop_board.sv */
// board model of the circuitry hanging on the port pins
`timescale 1ns/1ps
`default_nettype none

module iop_board (
  // clock
  input  wire logic        hclk,
  // design pin drivers
  input  wire logic [23:0] pin_out,
  input  wire logic [23:0] pin_oe,
  input  wire logic [23:0] pin_pull_en,
  // external drivers from the bench
  input  wire logic [23:0] ext_drv,
  input  wire logic [23:0] ext_val,
  output      logic [23:0] pin_in
);
  logic [23:0] flt_r = 24'h5a5a5a;

  // a floating line wanders each cycle so a stale level never reads as valid
  always @(posedge hclk)
    flt_r <= ~flt_r;

  // wired level: own drive, then board driver, then pull-up, else floating
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
                | (~pin_oe & ~ext_drv & (pin_pull_en | flt_r));
endmodule
`default_nettype wire

/* verif/iop_checker.sv */
// port-level assertions for the i/o port block
`timescale 1ns/1ps
`default_nettype none

module iop_chk (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  // pins and outputs
  input  wire logic [23:0] pin_out,
  input  wire logic [23:0] pin_oe,
  input  wire logic [23:0] pin_pull_en,
  input  wire logic        cpu_clk,
  input  wire logic        ext_int_group0,
  input  wire logic        ext_int_group1,
  input  wire logic        irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = hsel && hready && htrans[1] && ce;

  ////////////////////////////////////////
  a_reset_quiet: assert property ($rose(hresetn) |-> !cpu_clk && pin_oe == 24'h0 && !irq)
    else $error("outputs not idle after reset");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_zero: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_od_no_pull: assert property ((pin_pull_en & 24'h000050) == 24'h0)
    else $error("pull-up on true open-drain pin");
  a_od_sink_only: assert property ((pin_oe & pin_out & 24'h000050) == 24'h0)
    else $error("true open-drain pin driven high");
  a_input_no_drive: assert property ((pin_pull_en & pin_oe & ~24'h040000) == 24'h0)
    else $error("input pin driven");
  a_irq_source: assert property (irq |-> ext_int_group0 || ext_int_group1)
    else $error("irq without status");
  a_status_sticky: assert property ($fell(ext_int_group0) |->
    $past(take && hwrite && haddr[7:0] == 8'h14, 2))
    else $error("status cleared without write");
endmodule

bind iop_top iop_chk iop_chk_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en), .cpu_clk(cpu_clk),
  .ext_int_group0(ext_int_group0), .ext_int_group1(ext_int_group1), .irq(irq));
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the i/o port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, v) begin tests_run++; if ((v) !== (e)) begin error_cnt++; \
  $display("Error %s exp %0h got %0h", nm, e, v); end end

module tb;
  logic        hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, cc = 1;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rdv, r, d, dr, op;
  logic [23:0] ext_drv = 0, ext_val = 0;
  wire  [31:0] hrdata;
  wire  [23:0] pin_in, pin_out, pin_oe, pin_pull_en;
  wire         hreadyout, hresp, cpu_clk, eg0, eg1, irq;
  int          error_cnt = 0, tests_run = 0, cyc = 0, n;
  logic [7:0]  mt [5] = '{8'h00, 8'h01, 8'h05, 8'h03, 8'h07};

  iop_top iop_top_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cc_int_mask(cc), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_en(pin_pull_en), .cpu_clk(cpu_clk), .ext_int_group0(eg0),
    .ext_int_group1(eg1), .irq(irq));
  iop_board iop_board_inst (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en),
    .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));

  ////////////////////////////////////////
  // clock and hang guard
  always #20 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  task end_sim();
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one single ahb-lite transfer; read data lands in rdv
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] dat);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= dat;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask

  // full cpu_clk period, taken on the third rise to skip a stale count
  task meas(output int cnt);
    logic p;
    int   c;
    p = cpu_clk;
    c = 0;
    cnt = 0;
    while (c < 3 && cnt < 300)
    begin
      @(posedge hclk);
      #1;
      cnt++;
      if (cpu_clk && !p)
      begin
        c++;
        if (c < 3) cnt = 0;
      end
      p = cpu_clk;
    end
  endtask

  function int per(input logic [7:0] m);
    per = !m[0] ? 2 : m[2:1] == 2'h0 ? 4 : m[2:1] == 2'h2 ? 8 : m[2:1] == 2'h1 ? 16 : 32;
  endfunction

  localparam logic [23:0] OD = 24'h000050;

  ////////////////////////////////////////
  initial
  begin
    void'($urandom(32'he0db));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(0, 0, 0); `CHK("misc reset", 32'h0, rdv)
    cc <= 1'b0;
    xfer(1, 0, 32'hff); xfer(0, 0, 0); `CHK("misc locked", 32'h27, rdv)
    cc <= 1'b1;
    r = $urandom;
    xfer(1, 0, r); xfer(0, 0, 0); `CHK("misc open", {24'h0, r[7:0]}, rdv)
    d = 32'h20 + 4 * ($urandom % 56);
    xfer(1, d, r); xfer(0, d, 0); `CHK("unmapped", 32'h0, rdv)
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      xfer(1, 0, {24'h0, mt[i]}); meas(n); `CHK("cpu_clk period", per(mt[i]), n)
    end
    // clock out on pin 18 while bit 5 is set, checked on pin_oe with its direction and option bits still zero
    xfer(1, 0, 32'h21); #1; `CHK("clkout oe", 1'b1, pin_oe[18])
    xfer(1, 0, 32'h0); #1; `CHK("clkout off", 1'b0, pin_oe[18])
    $display("test clock done");
    for (int i = 0; i < 6; i++)
    begin
      d = (i == 0) ? '1 : $urandom;
      dr = (i == 0) ? '1 : $urandom;
      op = (i == 0) ? '1 : $urandom;
      xfer(1, 4, d); xfer(1, 8, dr); xfer(1, 12, op); #1;
      `CHK("pin_oe", dr[23:0] & ((op[23:0] & ~OD) | ~d[23:0]), pin_oe)
      `CHK("pin_out", dr[23:0] & op[23:0] & ~OD & d[23:0], pin_out)
      `CHK("pin_pull_en", ~dr[23:0] & op[23:0] & ~OD, pin_pull_en)
    end
    $display("test drivers done");
    // pins 0 and 8 as interrupt inputs, reached by safe steps only; group0 unmasked
    xfer(1, 8, 0); xfer(1, 12, 32'h101); xfer(1, 32'h18, 1);
    ext_drv <= 24'h000101;
    ext_val <= 24'h000101;
    for (int g = 0; g < 2; g++)
      for (int s = 0; s < 4; s++)
      begin
        xfer(1, 0, g ? s << 6 : s << 3); repeat (8) @(posedge hclk);
        xfer(1, 32'h14, 3); xfer(0, 32'h14, 0); `CHK("status idle", 32'h0, rdv)
        ext_val[g * 8] <= 1'b0; repeat (8) @(posedge hclk);
        xfer(0, 32'h14, 0); `CHK("status fall", 32'(s != 1) << g, rdv)
        `CHK("ext_int", 2'(32'(s != 1) << g), {eg1, eg0})
        `CHK("irq", 1'(g == 0 && s != 1), irq)
        xfer(0, 32'h10, 0); `CHK("level", 1'b0, rdv[g * 8])
        xfer(1, 32'h14, 3); xfer(0, 32'h14, 0); `CHK("status low", 32'(s == 0) << g, rdv)
        ext_val[g * 8] <= 1'b1; repeat (8) @(posedge hclk);
        xfer(0, 32'h14, 0); `CHK("status rise", 32'(s != 2) << g, rdv)
      end
    xfer(1, 12, 0); xfer(1, 0, 32'h10); xfer(1, 32'h14, 3);
    ext_val[0] <= 1'b0; repeat (8) @(posedge hclk);
    xfer(0, 32'h14, 0); `CHK("status no int mode", 32'h0, rdv)
    // port c pin 16 moved to group one, falling edge only, driven high before it becomes an interrupt input
    ext_drv[16] <= 1'b1;
    ext_val[16] <= 1'b1;
    xfer(1, 32'h1c, 1); xfer(1, 12, 32'h10000); xfer(1, 0, 32'h80); repeat (8) @(posedge hclk);
    xfer(1, 32'h14, 3); ext_val[16] <= 1'b0; repeat (8) @(posedge hclk);
    xfer(0, 32'h14, 0); `CHK("status route", 32'h2, rdv)
    $display("test interrupts done");
    end_sim();
  end
endmodule
`default_nettype wire
